// ### rtl/nis_consts.vh
// Constants for the low interrupt event status block
`ifndef NIS_CONSTS_VH
`define NIS_CONSTS_VH

// Register port addresses
`define NIS_ADDR_W        4
`define NIS_ADDR_STATUS   4'h5
`define NIS_ADDR_MASK     4'h6
`define NIS_ADDR_RXCTL    4'h7
`define NIS_ADDR_TIMER    4'h8
`define NIS_ADDR_CRCT     4'h9
`define NIS_ADDR_FAET     4'ha
`define NIS_ADDR_MPT      4'hb
`define NIS_ADDR_RXST     4'hc

// Register widths and reset values
`define NIS_DW            16
`define NIS_NBITS         9
`define NIS_ZERO16        16'h0000
`define NIS_ONES16        16'hffff
`define NIS_ZERO32        32'h00000000
`define NIS_ONES32        32'hffffffff
`define NIS_ZERO9         9'h000
`define NIS_PTR_W         8
`define NIS_PTR_ZERO      8'h00
`define NIS_PTR_ONE       8'h01

// Status bit positions
`define NIS_B_TX_ERROR_FLAG        8
`define NIS_B_TC          7
`define NIS_B_RDE         6
`define NIS_B_RBE         5
`define NIS_B_RX_AREA_EXCEEDED_FLAG        4
`define NIS_B_CRC         3
`define NIS_B_FAE         2
`define NIS_B_MP          1
`define NIS_B_RFO         0

// Receive control bits
`define NIS_RXCTL_W       2
`define NIS_RXCTL_ZERO    2'h0
`define NIS_RXCTL_RST     0
`define NIS_RXCTL_TMREN   1

// Resource engine states
`define NIS_ST_W          2
`define NIS_ST_IDLE       2'h0
`define NIS_ST_RUN        2'h1
`define NIS_ST_STOP       2'h2

`endif

// ### rtl/nis_flag.v
// One sticky status flag with write-one-to-clear and mask gating
`timescale 1ns/10ps
module nis_flag
(
  input  wire CLK,
  input  wire SYS_RST,
  input  wire CE,
  input  wire set_i,
  input  wire clr_i,
  input  wire mask_i,
  output reg  flag_reg,
  output wire pend_o
);

  // RQ19 set beats clear
  always @(posedge CLK)
    if (SYS_RST)
      flag_reg <= 1'b0;
    else if (CE)
      flag_reg <= set_i | (flag_reg & ~clr_i);

  // RQ18 masked pending
  assign pend_o = flag_reg & mask_i;

endmodule // nis_flag

// ### rtl/nis_status_low.v
// Low interrupt event status bits with their event sources
// What this block and its driver do
// RQ1 - Set bit 8 when a packet ends with any transmit error cause.
// RQ2 - Set bit 7 when the 32-bit timer wraps zero to all ones.
// RQ3 - Set bit 6 when end-of-list is found in descriptor area.
// RQ4 - Set bit 5 when resource read pointer equals write pointer.
// RQ5 - Bit 5 rises on reading the last descriptor, before final buffer.
// RQ6 - Stop reception after last buffer; resume on pointer advance and clear.
// RQ7 - Clearing bit 5 with new resources fetches next descriptor; here only in the STOP state, not while running.
// RQ8 - Software adds resources before clearing bit 5.
// RQ9 - On buffer area end: set bit 4, abort, fetch next descriptor.
// RQ10 - After overflow, drop remaining buffer space and write no descriptor.
// RQ11 - Set bit 3 when the CRC tally wraps all ones to zero.
// RQ12 - Set bit 2 when the alignment tally wraps all ones to zero.
// RQ13 - Set bit 1 when the missed tally wraps all ones to zero.
// RQ14 - Set bit 0 when receive FIFO fills before bus is granted.
// RQ15 - Transmit underrun goes to transmit control, not overrun bit.
// RQ16 - Writing one clears a status bit; zero leaves it.
// RQ17 - Hardware reset clears status; software reset leaves it.
// RQ18 - Interrupt output high only for a set and enabled bit.
// RQ19 - Event in the clearing cycle wins; bit stays set.
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "nis_consts.vh"
module nis_status_low
(
  input  wire                   CLK,
  input  wire                   SYS_RST,
  input  wire                   CE,
  input  wire [`NIS_ADDR_W-1:0] ADDR,
  input  wire [`NIS_DW-1:0]     WDATA,
  input  wire                   WR,
  input  wire                   RD,
  output reg  [`NIS_DW-1:0]     RDATA,
  input  wire                   TX_DONE,
  input  wire                   TX_BYTE_COUNT_MISMATCH,
  input  wire                   TX_EXCESS_COLLISIONS,
  input  wire                   TX_FIFO_UNDERRUN,
  input  wire                   TX_EXCESS_DEFERRAL,
  output reg                    TX_UNDERRUN_REPORT,
  input  wire                   RX_DESC_EOL_SEEN,
  input  wire                   RX_PKT_START,
  input  wire                   RX_PKT_DONE,
  input  wire                   RX_BUF_DONE,
  input  wire                   RX_AREA_END,
  input  wire                   RX_CRC_ERROR,
  input  wire                   RX_ALIGN_ERROR,
  input  wire                   RX_MISSED,
  input  wire                   RX_FIFO_FULL,
  input  wire                   BUS_GRANT,
  output wire                   RX_ENABLE,
  output reg                    RX_ABORT,
  output reg                    RX_DESC_WRITE,
  output reg                    RX_RESOURCE_FETCH,
  output wire                   INT
);

  reg  [`NIS_NBITS-1:0]   mask_reg;
  reg  [`NIS_RXCTL_W-1:0] rxctl_reg;
  reg  [31:0]             timer_reg;
  reg  [`NIS_DW-1:0]      crc_tally_reg;
  reg  [`NIS_DW-1:0]      align_tally_reg;
  reg  [`NIS_DW-1:0]      missed_tally_reg;
  reg  [`NIS_PTR_W-1:0]   rrp_reg;
  reg  [`NIS_PTR_W-1:0]   rwp_reg;
  reg  [`NIS_ST_W-1:0]    state_reg;
  reg  [`NIS_ST_W-1:0]    state_next;
  reg                     last_desc_reg;
  reg                     in_pkt_reg;
  wire [`NIS_NBITS-1:0]   set_vec;
  wire [`NIS_NBITS-1:0]   clr_vec;
  wire [`NIS_NBITS-1:0]   flag_vec;
  wire [`NIS_NBITS-1:0]   pend_vec;
  wire                    wr_status;
  wire                    fetch_req;
  wire                    rbe_clear;
  wire                    tx_err;

  function hit;
    input [`NIS_ADDR_W-1:0] a;
    input [`NIS_ADDR_W-1:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  assign wr_status = CE & WR & hit(ADDR, `NIS_ADDR_STATUS);

  // RQ16 write one clears
  assign clr_vec = wr_status ? WDATA[`NIS_NBITS-1:0] : `NIS_ZERO9;

  // Software reset bit halts the resource engine but leaves status flags alone
  always @(posedge CLK)
    if (SYS_RST)
    begin
      mask_reg  <= `NIS_ZERO9;
      rxctl_reg <= `NIS_RXCTL_ZERO;
    end
    else if (CE & WR)
    begin
      if (hit(ADDR, `NIS_ADDR_MASK))
        mask_reg <= WDATA[`NIS_NBITS-1:0];
      if (hit(ADDR, `NIS_ADDR_RXCTL))
        rxctl_reg <= WDATA[`NIS_RXCTL_W-1:0];
    end

  ////////////////////////////////////////////////////////////////////////////
  // Timer and tally counters

  // RQ2 timer wrap
  assign set_vec[`NIS_B_TC] = CE & rxctl_reg[`NIS_RXCTL_TMREN]
                              & (timer_reg == `NIS_ZERO32)
                              & ~(WR & hit(ADDR, `NIS_ADDR_TIMER));

  always @(posedge CLK)
    if (SYS_RST)
      timer_reg <= `NIS_ZERO32;
    else if (CE & WR & hit(ADDR, `NIS_ADDR_TIMER))
      timer_reg <= {`NIS_ZERO16, WDATA};
    else if (CE & rxctl_reg[`NIS_RXCTL_TMREN])
      timer_reg <= timer_reg - 32'h00000001;

  // RQ11 CRC tally wrap
  assign set_vec[`NIS_B_CRC] = CE & RX_CRC_ERROR
                               & (crc_tally_reg == `NIS_ONES16)
                               & ~(WR & hit(ADDR, `NIS_ADDR_CRCT));
  // RQ12 alignment tally wrap
  assign set_vec[`NIS_B_FAE] = CE & RX_ALIGN_ERROR
                               & (align_tally_reg == `NIS_ONES16)
                               & ~(WR & hit(ADDR, `NIS_ADDR_FAET));
  // RQ13 missed tally wrap
  assign set_vec[`NIS_B_MP] = CE & RX_MISSED
                              & (missed_tally_reg == `NIS_ONES16)
                              & ~(WR & hit(ADDR, `NIS_ADDR_MPT));

  always @(posedge CLK)
    if (SYS_RST)
    begin
      crc_tally_reg    <= `NIS_ZERO16;
      align_tally_reg  <= `NIS_ZERO16;
      missed_tally_reg <= `NIS_ZERO16;
    end
    else if (CE)
    begin
      if (WR & hit(ADDR, `NIS_ADDR_CRCT))
        crc_tally_reg <= WDATA;
      else if (RX_CRC_ERROR)
        crc_tally_reg <= crc_tally_reg + 16'h0001;
      if (WR & hit(ADDR, `NIS_ADDR_FAET))
        align_tally_reg <= WDATA;
      else if (RX_ALIGN_ERROR)
        align_tally_reg <= align_tally_reg + 16'h0001;
      if (WR & hit(ADDR, `NIS_ADDR_MPT))
        missed_tally_reg <= WDATA;
      else if (RX_MISSED)
        missed_tally_reg <= missed_tally_reg + 16'h0001;
    end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit, receive FIFO and descriptor list events

  // RQ1 transmit error
  assign tx_err = TX_BYTE_COUNT_MISMATCH | TX_EXCESS_COLLISIONS
                  | TX_FIFO_UNDERRUN | TX_EXCESS_DEFERRAL;
  assign set_vec[`NIS_B_TX_ERROR_FLAG] = CE & TX_DONE & tx_err;

  // RQ15 underrun to transmit control
  always @(posedge CLK)
    if (SYS_RST)
      TX_UNDERRUN_REPORT <= 1'b0;
    else if (CE & TX_DONE)
      TX_UNDERRUN_REPORT <= TX_FIFO_UNDERRUN;

  // RQ14 FIFO overrun
  assign set_vec[`NIS_B_RFO] = CE & RX_FIFO_FULL & ~BUS_GRANT;

  // RQ3 descriptors exhausted
  assign set_vec[`NIS_B_RDE] = CE & RX_DESC_EOL_SEEN;

  ////////////////////////////////////////////////////////////////////////////
  // Resource engine

  // Pointers are word indexes into the resource area; write pointer is
  // software-owned, so RQ8 ordering is up to the driver.
  assign rbe_clear = wr_status & WDATA[`NIS_B_RBE];
  // RQ7 clear refetches
  assign fetch_req = (state_reg == `NIS_ST_STOP) & rbe_clear
                     & (rwp_reg != rrp_reg);

  // RQ4 pointers meet
  // RQ5 early warning
  assign set_vec[`NIS_B_RBE] = CE & RX_RESOURCE_FETCH
                               & (rrp_reg == rwp_reg);

  // RQ9 area end flag
  assign set_vec[`NIS_B_RX_AREA_EXCEEDED_FLAG] = CE & RX_AREA_END & in_pkt_reg;

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `NIS_ST_IDLE:
        if ((rwp_reg != rrp_reg) & ~rxctl_reg[`NIS_RXCTL_RST])
          state_next = `NIS_ST_RUN;
      `NIS_ST_RUN:
        if (RX_BUF_DONE & last_desc_reg & ~RX_RESOURCE_FETCH)
          state_next = `NIS_ST_STOP;
      `NIS_ST_STOP:
        if (fetch_req)
          state_next = `NIS_ST_RUN;
      default:
        state_next = `NIS_ST_IDLE;
    endcase
  end

  always @(posedge CLK)
    if (SYS_RST)
    begin
      state_reg         <= `NIS_ST_IDLE;
      rrp_reg           <= `NIS_PTR_ZERO;
      rwp_reg           <= `NIS_PTR_ZERO;
      last_desc_reg     <= 1'b0;
      in_pkt_reg        <= 1'b0;
      RX_ABORT          <= 1'b0;
      RX_DESC_WRITE     <= 1'b0;
      RX_RESOURCE_FETCH <= 1'b0;
    end
    else if (CE)
    begin
      RX_ABORT          <= 1'b0;
      RX_DESC_WRITE     <= 1'b0;
      RX_RESOURCE_FETCH <= 1'b0;
      if (rxctl_reg[`NIS_RXCTL_RST])
        state_reg <= `NIS_ST_IDLE;
      else
        state_reg <= state_next;
      if (WR & hit(ADDR, `NIS_ADDR_RXST))
        rwp_reg <= WDATA[`NIS_PTR_W-1:0];
      if (RX_PKT_START & RX_ENABLE)
        in_pkt_reg <= 1'b1;
      // RQ9 abort and fetch
      // RQ10 no descriptor, buffer dropped
      if (RX_AREA_END & in_pkt_reg)
      begin
        in_pkt_reg <= 1'b0;
        RX_ABORT   <= 1'b1;
      end
      else if (RX_PKT_DONE & in_pkt_reg)
      begin
        in_pkt_reg    <= 1'b0;
        RX_DESC_WRITE <= 1'b1;
      end
      // Fetch on start-up, buffer end, area overflow or refill after clear
      if ((state_reg == `NIS_ST_IDLE & state_next == `NIS_ST_RUN)
          | fetch_req
          | ((RX_BUF_DONE | (RX_AREA_END & in_pkt_reg))
             & state_reg == `NIS_ST_RUN & ~last_desc_reg))
      begin
        RX_RESOURCE_FETCH <= 1'b1;
        rrp_reg           <= rrp_reg + `NIS_PTR_ONE;
        last_desc_reg     <= (rrp_reg + `NIS_PTR_ONE == rwp_reg);
      end
    end

  // RQ6 stop until refill
  assign RX_ENABLE = (state_reg == `NIS_ST_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Flags, interrupt and read port

  genvar g;
  generate
    for (g = 0; g < `NIS_NBITS; g = g + 1)
    begin : flags
      // RQ17 hard reset only
      nis_flag u_flag
      (
        .CLK      (CLK),
        .SYS_RST  (SYS_RST),
        .CE       (CE),
        .set_i    (set_vec[g]),
        .clr_i    (clr_vec[g]),
        .mask_i   (mask_reg[g]),
        .flag_reg (flag_vec[g]),
        .pend_o   (pend_vec[g])
      );
    end
  endgenerate

  // RQ18 interrupt level
  assign INT = |pend_vec;

  always @(posedge CLK)
    if (SYS_RST)
      RDATA <= `NIS_ZERO16;
    else if (CE)
    begin
      RDATA <= `NIS_ZERO16;
      if (RD)
        case (ADDR)
          `NIS_ADDR_STATUS: RDATA <= {7'h00, flag_vec};
          `NIS_ADDR_MASK:   RDATA <= {7'h00, mask_reg};
          `NIS_ADDR_RXCTL:  RDATA <= {14'h0000, rxctl_reg};
          `NIS_ADDR_TIMER:  RDATA <= timer_reg[`NIS_DW-1:0];
          `NIS_ADDR_CRCT:   RDATA <= crc_tally_reg;
          `NIS_ADDR_FAET:   RDATA <= align_tally_reg;
          `NIS_ADDR_MPT:    RDATA <= missed_tally_reg;
          `NIS_ADDR_RXST:   RDATA <= {rrp_reg, rwp_reg};
          default:          RDATA <= `NIS_ZERO16;
        endcase
    end

endmodule // nis_status_low

// ### dv/nis_status_low_checker.sv
// Port assertions for the low interrupt event status block
`timescale 1ns/10ps
`include "nis_consts.vh"
module nis_status_low_checker
(
  input logic        CLK,
  input logic        SYS_RST,
  input logic        CE,
  input logic [3:0]  ADDR,
  input logic [15:0] WDATA,
  input logic        WR,
  input logic        RD,
  input logic [15:0] RDATA,
  input logic        TX_DONE,
  input logic        TX_BYTE_COUNT_MISMATCH,
  input logic        TX_EXCESS_COLLISIONS,
  input logic        TX_FIFO_UNDERRUN,
  input logic        TX_EXCESS_DEFERRAL,
  input logic        TX_UNDERRUN_REPORT,
  input logic        RX_DESC_EOL_SEEN,
  input logic        RX_FIFO_FULL,
  input logic        BUS_GRANT,
  input logic        RX_AREA_END,
  input logic        RX_ENABLE,
  input logic        RX_RESOURCE_FETCH,
  input logic        RX_ABORT,
  input logic        RX_DESC_WRITE,
  input logic        INT
);
  logic [8:0] mask_q;
  wire        rd_st = CE && RD && ADDR == `NIS_ADDR_STATUS;
  wire        wr_st = CE && WR && ADDR == `NIS_ADDR_STATUS;
  wire        wr_mk = CE && WR && ADDR == `NIS_ADDR_MASK;
  wire        txe   = CE && TX_DONE && (TX_BYTE_COUNT_MISMATCH ||
                      TX_EXCESS_COLLISIONS || TX_FIFO_UNDERRUN ||
                      TX_EXCESS_DEFERRAL);
  wire        ovr   = CE && RX_FIFO_FULL && !BUS_GRANT;
  //////////////////////////////////////////////////////////////////////////
  // Shadow of the mask, since the design's copy is not at the ports
  always @(posedge CLK)
  begin
    if (SYS_RST)
      mask_q <= 9'h000;
    else if (wr_mk)
      mask_q <= WDATA[8:0];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_TX_ERROR_FLAG: assert property (txe ##1 !wr_st ##1 rd_st |=> RDATA[8])
    else $error("transmit error flag missing");
  AST_RDE: assert property (CE && RX_DESC_EOL_SEEN ##1 !wr_st ##1 rd_st
    |=> RDATA[6]) else $error("descriptor exhausted flag missing");
  AST_RFO: assert property (ovr ##1 !wr_st ##1 rd_st |=> RDATA[0])
    else $error("fifo overrun flag missing");
  AST_CLR: assert property (wr_st && WDATA[8] && !TX_DONE ##1 !TX_DONE
    ##1 rd_st |=> !RDATA[8]) else $error("write one did not clear");
  AST_SETWINS: assert property (wr_st && WDATA[0] && ovr ##1 !wr_st
    ##1 rd_st |=> RDATA[0]) else $error("clear beat a same cycle event");
  AST_INT_OFF: assert property (mask_q == 9'h000 |-> !INT)
    else $error("interrupt with all bits masked");
  AST_INT_ON: assert property (txe && TX_EXCESS_COLLISIONS && mask_q[8]
    && !wr_mk |=> INT) else $error("enabled event gave no interrupt");
  AST_TXUR: assert property (CE && TX_DONE |=>
    TX_UNDERRUN_REPORT == $past(TX_FIFO_UNDERRUN))
    else $error("underrun report wrong");
  AST_NO_DESC: assert property (RX_ABORT |-> !RX_DESC_WRITE &&
    ($past(CE && RX_AREA_END) || $past(!CE && RX_ABORT)))
    else $error("descriptor written or abort without area end");
  AST_RUN_FETCH: assert property ($rose(RX_ENABLE) |->
    RX_RESOURCE_FETCH) else $error("reception resumed without a fetch");
endmodule // nis_status_low_checker

bind nis_status_low nis_status_low_checker nis_status_low_checker_inst (.*);

// ### dv/nis_status_low_test.sv
// Self-checking bench for the low interrupt event status block
`timescale 1ns/10ps
`include "nis_consts.vh"
module nis_status_low_test;
  localparam logic [3:0] ST = `NIS_ADDR_STATUS;
  localparam logic [3:0] MK = `NIS_ADDR_MASK;
  localparam logic [3:0] RX = `NIS_ADDR_RXCTL;
  localparam logic [3:0] TM = `NIS_ADDR_TIMER;
  localparam logic [3:0] TL = `NIS_ADDR_CRCT;
  localparam logic [3:0] RP = `NIS_ADDR_RXST;
  logic        CLK = 0;
  logic        SYS_RST = 1;
  logic        ce = 1;
  logic        wr = 0;
  logic        rd = 0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [14:0] ev = 15'h0000;
  wire  [15:0] rdata;
  wire         tx_ur, rx_en, abrt, dwr, fetch, irq;
  int          bad_count = 0;
  int          n_tests = 0;
  int          fcnt = 0;
  int          acnt = 0;
  int          dcnt = 0;
  always #2.5 CLK = ~CLK;
  nis_status_low nis_status_low_inst (.CLK(CLK), .SYS_RST(SYS_RST), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .TX_DONE(ev[0]), .TX_BYTE_COUNT_MISMATCH(ev[1]),
    .TX_EXCESS_COLLISIONS(ev[2]), .TX_FIFO_UNDERRUN(ev[3]),
    .TX_EXCESS_DEFERRAL(ev[4]), .TX_UNDERRUN_REPORT(tx_ur),
    .RX_DESC_EOL_SEEN(ev[5]), .RX_PKT_START(ev[6]), .RX_PKT_DONE(ev[7]),
    .RX_BUF_DONE(ev[8]), .RX_AREA_END(ev[9]), .RX_CRC_ERROR(ev[10]),
    .RX_ALIGN_ERROR(ev[11]), .RX_MISSED(ev[12]), .RX_FIFO_FULL(ev[13]),
    .BUS_GRANT(~ev[14]), .RX_ENABLE(rx_en), .RX_ABORT(abrt),
    .RX_DESC_WRITE(dwr), .RX_RESOURCE_FETCH(fetch), .INT(irq));
  always @(posedge CLK)
  begin
    fcnt <= fcnt + fetch;
    acnt <= acnt + abrt;
    dcnt <= dcnt + dwr;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge CLK);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] e);
    @(posedge CLK);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLK);
    rd <= 1'b0;
    @(negedge CLK);
    chk("rdata", e, rdata);
  endtask
  task automatic pulse(input logic [14:0] m);
    @(posedge CLK);
    ev <= m;
    @(posedge CLK);
    ev <= 15'h0000;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
    @(negedge CLK);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5000) @(posedge CLK);
    bad_count++;
    test_done;
  end
  initial
  begin
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    rreg(ST, 16'h0000);
    wreg(MK, 16'h01ff);
    for (int i = 1; i < 5; i++)
    begin
      pulse(15'h0001 | (15'h0001 << i));
      idle(0);
      chk("irq", 16'h0001, 16'(irq));
      chk("underrun", 16'(i == 3), 16'(tx_ur));
      rreg(ST, 16'h0100);
      wreg(ST, 16'h0100);
      rreg(ST, 16'h0000);
    end
    idle(0);
    chk("irq", 16'h0000, 16'(irq));
    pulse(15'h0001);
    rreg(ST, 16'h0000);
    pulse(15'h0020);
    rreg(ST, 16'h0040);
    wreg(ST, 16'h0040);
    pulse(15'h2000);
    rreg(ST, 16'h0000);
    pulse(15'h6000);
    rreg(ST, 16'h0001);
    wreg(ST, 16'h0000);
    rreg(ST, 16'h0001);
    @(posedge CLK);
    ev <= 15'h6000;
    addr <= ST;
    wdata <= 16'h0001;
    wr <= 1'b1;
    @(posedge CLK);
    ev <= 15'h0000;
    wr <= 1'b0;
    rreg(ST, 16'h0001);
    wreg(MK, 16'h0000);
    idle(0);
    chk("irq", 16'h0000, 16'(irq));
    wreg(MK, 16'h0001);
    idle(0);
    chk("irq", 16'h0001, 16'(irq));
    wreg(RX, 16'h0001);
    wreg(RX, 16'h0000);
    rreg(ST, 16'h0001);
    wreg(ST, 16'h01ff);
    for (int i = 0; i < 3; i++)
    begin
      wreg(4'(TL + i), 16'hfffe);
      pulse(15'h0400 << i);
      rreg(ST, 16'h0000);
      pulse(15'h0400 << i);
      rreg(4'(TL + i), 16'h0000);
      rreg(ST, 16'h0008 >> i);
      wreg(ST, 16'h01ff);
    end
    wreg(TM, 16'h0003);
    wreg(RX, 16'h0002);
    idle(8);
    wreg(RX, 16'h0000);
    rreg(ST, 16'h0080);
    wreg(4'hf, 16'hffff);
    rreg(4'hf, 16'h0000);
    @(posedge CLK);
    SYS_RST <= 1'b1;
    @(posedge CLK);
    SYS_RST <= 1'b0;
    rreg(ST, 16'h0000);
    wreg(RP, 16'h0004);
    idle(3);
    chk("rx_en", 16'h0001, 16'(rx_en));
    pulse(15'h0040);
    pulse(15'h0200);
    idle(3);
    chk("abort", 16'h0001, 16'(acnt));
    chk("desc", 16'h0000, 16'(dcnt));
    chk("fetch", 16'h0002, 16'(fcnt));
    pulse(15'h0100);
    rreg(ST, 16'h0010);
    pulse(15'h0100);
    rreg(ST, 16'h0030);
    chk("rx_en", 16'h0001, 16'(rx_en));
    pulse(15'h0100);
    wreg(RP, 16'h0005);
    idle(3);
    chk("rx_en", 16'h0000, 16'(rx_en));
    wreg(ST, 16'h0020);
    idle(3);
    chk("fetch", 16'h0005, 16'(fcnt));
    chk("rx_en", 16'h0001, 16'(rx_en));
    rreg(RP, 16'h0505);
    wreg(ST, 16'h01ff);
    pulse(15'h0040);
    pulse(15'h0080);
    pulse(15'h0200);
    idle(1);
    chk("desc", 16'h0001, 16'(dcnt));
    chk("abort", 16'h0001, 16'(acnt));
    rreg(ST, 16'h0000);
    // Clock enable low must swallow the event
    @(posedge CLK);
    ce <= 1'b0;
    pulse(15'h0020);
    ce <= 1'b1;
    rreg(ST, 16'h0000);
    test_done;
  end
endmodule // nis_status_low_test
